/* hw/adsb_defs.vh */
// register offsets, field positions, reset values and state codes for sequence b control
`ifndef ADSB_DEFS_VH
`define ADSB_DEFS_VH
// ==========================================
// register byte offsets
`define ADSB_OFF_CTRL     12'h000
`define ADSB_OFF_GRES     12'h004
`define ADSB_OFF_STAT     12'h008
// ==========================================
// control register fields
`define ADSB_CH_HI        11
`define ADSB_CH_LO        0
`define ADSB_TSEL_HI      14
`define ADSB_TSEL_LO      12
`define ADSB_POL_BIT      18
`define ADSB_SKIP_BIT     19
`define ADSB_START_BIT    26
`define ADSB_BURST_BIT    27
`define ADSB_STEP_BIT     28
`define ADSB_MODE_BIT     30
`define ADSB_ENA_BIT      31
// ==========================================
// global result fields
`define ADSB_RES_HI       15
`define ADSB_RES_LO       4
`define ADSB_GCH_HI       29
`define ADSB_GCH_LO       26
`define ADSB_OVR_BIT      30
`define ADSB_FRESH_BIT    31
// ==========================================
// status register fields
`define ADSB_SFLAG_BIT    0
`define ADSB_OVRIE_BIT    1
`define ADSB_BUSY_BIT     2
// ==========================================
// reset values
`define ADSB_CTRL_RST     32'h0000_0000
`define ADSB_CHAN_RST     4'h0
`define ADSB_RES_RST      12'h000
// ==========================================
// sequencer states
`define ADSB_ST_IDLE      2'h0
`define ADSB_ST_LAUNCH    2'h1
`define ADSB_ST_WAIT      2'h2
`endif

/* hw/adsb_trig_edge.v */
// trigger select, optional synchroniser and polarity edge detect
`timescale 1ns/100ps
`default_nettype none
module adsb_trig_edge (
	input  wire       clk,
	input  wire       rstn,
	input  wire [7:0] hw_trig,
	input  wire [2:0] trig_sel,
	input  wire       sync_skip,
	input  wire       edge_pol,
	output wire       trig_edge
);
	reg  [7:0] meta_q;
	reg  [7:0] sync_q;
	reg        prev_q;
	wire       cur;

	// ==========================================
	// two-stage synchroniser per input
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_sync
			always @(posedge clk) begin
				if (!rstn) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= hw_trig[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	// ==========================================
	// R3: bypass or synchronised path
	assign cur = sync_skip ? hw_trig[trig_sel] : sync_q[trig_sel];

	always @(posedge clk) begin
		if (!rstn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= cur;
		end
	end

	// R1: R2: polarity selects edge
	assign trig_edge = edge_pol ? (cur & ~prev_q) : (~cur & prev_q);
endmodule // adsb_trig_edge
`default_nettype wire

/* hw/adsb_chan_pick.v */
// lowest enabled channel at or above a start index
`timescale 1ns/100ps
`default_nettype none
module adsb_chan_pick (
	input  wire [11:0] mask,
	input  wire [4:0]  from,
	output reg         found,
	output reg  [3:0]  chan
);
	integer k;

	// R19: descending scan, last match is the lowest
	always @* begin
		found = 1'b0;
		chan  = 4'h0;
		for (k = 11; k >= 0; k = k - 1) begin
			if (mask[k] && (k >= from)) begin
				found = 1'b1;
				chan  = k[3:0];
			end
		end
	end
endmodule // adsb_chan_pick
`default_nettype wire

/* hw/adsb_seq_ctrl.v */
// sequence b launch, sequencing and completion flag control with apb registers
// What this block does
// R1: polarity zero: falling edge of selected trigger starts a sequence.
// R2: polarity one: rising edge of selected trigger starts a sequence.
// R3: bypass bit routes the trigger around the synchroniser.
// R4: synchronous mode: bypass only for synchronous triggers; pulse one system clock.
// R5: asynchronous mode: bypass needs one converter clock pulse, else one system clock.
// R6: writing start launches one pass, same as a hardware trigger.
// R7: software must not write start while burst is set.
// R8: start is a momentary pulse and always reads zero.
// R9: burst repeats the sequence continuously and ignores other triggers.
// R10: clearing burst finishes the current pass then stops.
// R11: single step converts only the next enabled channel per trigger.
// R12: after the last enabled channel, single step restarts at the first.
// R13: single step flag timing still follows the retrieval mode bit.
// R14: mode zero: flag set per conversion, mirrors the result fresh flag.
// R15: mode zero: global overrun feeds the overrun interrupt when enabled.
// R16: mode one: flag set at sequence end, held until software or dma clear.
// R17: mode one: global overrun does not feed the overrun interrupt.
// R18: software writes zero to reserved bits; reads may return anything.
// R19: a pass converts enabled channels in ascending order from lowest.
// R20: trigger select field chooses the hardware trigger input.
// R21: disabled ignores triggers; clearing halts after current conversion, resumes next.
// R22: unbypassed trigger passes a two-stage synchroniser before edge detect.
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "adsb_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module adsb_seq_ctrl (
	input  wire        clk,
	input  wire        rstn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [7:0]  hw_trig,
	output reg         conv_start,
	output reg  [3:0]  conv_chan,
	input  wire        conv_done,
	input  wire [11:0] conv_result,
	input  wire        dma_clr,
	output wire        seq_flag,
	output wire        ovr_irq
);
	// ==========================================
	// declarations
	reg  [11:0] chans_q;
	reg  [2:0]  tsel_q;
	reg         pol_q;
	reg         skip_q;
	reg         burst_q;
	reg         step_q;
	reg         mode_q;
	reg         ena_q;
	reg         start_q;
	reg         ovr_ie_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [3:0]  ptr_q;
	reg  [3:0]  ptr_d;
	reg  [3:0]  cur_q;
	reg  [3:0]  cur_d;
	reg         eos_d;
	reg  [11:0] res_q;
	reg  [3:0]  gch_q;
	reg         fresh_q;
	reg         ovr_q;
	reg         sflag_q;
	wire        acc;
	wire        wr;
	wire        rd;
	wire        wr_ctrl;
	wire        wr_stat;
	wire        rd_gres;
	wire        mapped;
	wire        trig_edge;
	wire        launch;
	wire        pick_found;
	wire [3:0]  pick_chan;
	wire [4:0]  pick_from;

	// reset image of the control word, sliced per field below
	localparam [31:0] CTRL_RST = `ADSB_CTRL_RST;

	// ==========================================
	// address decode
	function is_reg;
		input [11:0] a;
		input [11:0] off;
		begin
			is_reg = (a == off);
		end
	endfunction

	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign rd      = acc & ~pwrite;
	assign mapped  = is_reg(paddr, `ADSB_OFF_CTRL) | is_reg(paddr, `ADSB_OFF_GRES)
		| is_reg(paddr, `ADSB_OFF_STAT);
	assign wr_ctrl = wr & is_reg(paddr, `ADSB_OFF_CTRL);
	assign wr_stat = wr & is_reg(paddr, `ADSB_OFF_STAT);
	assign rd_gres = rd & is_reg(paddr, `ADSB_OFF_GRES);
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// ==========================================
	// control register
	always @(posedge clk) begin
		if (!rstn) begin
			chans_q  <= CTRL_RST[`ADSB_CH_HI:`ADSB_CH_LO];
			tsel_q   <= CTRL_RST[`ADSB_TSEL_HI:`ADSB_TSEL_LO];
			pol_q    <= CTRL_RST[`ADSB_POL_BIT];
			skip_q   <= CTRL_RST[`ADSB_SKIP_BIT];
			burst_q  <= CTRL_RST[`ADSB_BURST_BIT];
			step_q   <= CTRL_RST[`ADSB_STEP_BIT];
			mode_q   <= CTRL_RST[`ADSB_MODE_BIT];
			ena_q    <= CTRL_RST[`ADSB_ENA_BIT];
			start_q  <= 1'b0;
			ovr_ie_q <= 1'b0;
		end else begin
			// R8: start only a one-cycle pulse
			start_q <= wr_ctrl & pwdata[`ADSB_START_BIT];
			if (wr_ctrl) begin
				chans_q <= pwdata[`ADSB_CH_HI:`ADSB_CH_LO];
				// R20: trigger input select
				tsel_q  <= pwdata[`ADSB_TSEL_HI:`ADSB_TSEL_LO];
				pol_q   <= pwdata[`ADSB_POL_BIT];
				skip_q  <= pwdata[`ADSB_SKIP_BIT];
				burst_q <= pwdata[`ADSB_BURST_BIT];
				step_q  <= pwdata[`ADSB_STEP_BIT];
				mode_q  <= pwdata[`ADSB_MODE_BIT];
				ena_q   <= pwdata[`ADSB_ENA_BIT];
			end
			if (wr_stat) begin
				ovr_ie_q <= pwdata[`ADSB_OVRIE_BIT];
			end
		end
	end

	// ==========================================
	// read mux
	always @* begin
		prdata = 32'h0000_0000;
		if (rd && is_reg(paddr, `ADSB_OFF_CTRL)) begin
			prdata[`ADSB_CH_HI:`ADSB_CH_LO]     = chans_q;
			prdata[`ADSB_TSEL_HI:`ADSB_TSEL_LO] = tsel_q;
			prdata[`ADSB_POL_BIT]               = pol_q;
			prdata[`ADSB_SKIP_BIT]              = skip_q;
			prdata[`ADSB_BURST_BIT]             = burst_q;
			prdata[`ADSB_STEP_BIT]              = step_q;
			prdata[`ADSB_MODE_BIT]              = mode_q;
			prdata[`ADSB_ENA_BIT]               = ena_q;
		end else if (rd_gres) begin
			prdata[`ADSB_RES_HI:`ADSB_RES_LO] = res_q;
			prdata[`ADSB_GCH_HI:`ADSB_GCH_LO] = gch_q;
			prdata[`ADSB_OVR_BIT]             = ovr_q;
			prdata[`ADSB_FRESH_BIT]           = fresh_q;
		end else if (rd && is_reg(paddr, `ADSB_OFF_STAT)) begin
			prdata[`ADSB_SFLAG_BIT] = seq_flag;
			prdata[`ADSB_OVRIE_BIT] = ovr_ie_q;
			prdata[`ADSB_BUSY_BIT]  = (state_q != `ADSB_ST_IDLE);
		end
	end

	// ==========================================
	// trigger path
	// R22: synchroniser inside edge unit
	adsb_trig_edge u_trig (
		.clk       (clk),
		.rstn      (rstn),
		.hw_trig   (hw_trig),
		.trig_sel  (tsel_q),
		.sync_skip (skip_q),
		.edge_pol  (pol_q),
		.trig_edge (trig_edge)
	);

	// R6: start acts as trigger
	// R9: burst relaunches, others ignored
	// R21: disabled ignores triggers
	assign launch = ena_q & (burst_q | trig_edge | start_q)
		& ~(burst_q & ~(trig_edge | start_q) & 1'b0);

	// ==========================================
	// channel search
	assign pick_from = (state_q == `ADSB_ST_WAIT) ? ({1'b0, cur_q} + 5'h01) : {1'b0, ptr_q};

	adsb_chan_pick u_pick (
		.mask  (chans_q),
		.from  (pick_from),
		.found (pick_found),
		.chan  (pick_chan)
	);

	// ==========================================
	// sequencer
	always @* begin
		state_d = state_q;
		ptr_d   = ptr_q;
		cur_d   = cur_q;
		eos_d   = 1'b0;
		case (state_q)
			`ADSB_ST_IDLE: begin
				if (launch) begin
					if (pick_found) begin
						cur_d   = pick_chan;
						state_d = `ADSB_ST_LAUNCH;
					end else begin
						ptr_d = 4'h0;
					end
				end
			end
			`ADSB_ST_LAUNCH: begin
				state_d = `ADSB_ST_WAIT;
			end
			`ADSB_ST_WAIT: begin
				if (conv_done) begin
					if (pick_found) begin
						ptr_d = pick_chan;
						// R11: single step stops here
						// R21: disable halts after current
						if (ena_q && !step_q) begin
							cur_d   = pick_chan;
							state_d = `ADSB_ST_LAUNCH;
						end else begin
							state_d = `ADSB_ST_IDLE;
						end
					end else begin
						// R10: pass ends, burst checked in idle
						// R12: wrap to first channel
						eos_d   = 1'b1;
						ptr_d   = 4'h0;
						state_d = `ADSB_ST_IDLE;
					end
				end
			end
			default: begin
				state_d = `ADSB_ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			state_q    <= `ADSB_ST_IDLE;
			ptr_q      <= `ADSB_CHAN_RST;
			cur_q      <= `ADSB_CHAN_RST;
			conv_start <= 1'b0;
			conv_chan  <= `ADSB_CHAN_RST;
		end else begin
			state_q    <= state_d;
			ptr_q      <= ptr_d;
			cur_q      <= cur_d;
			conv_start <= (state_d == `ADSB_ST_LAUNCH) && (state_q != `ADSB_ST_LAUNCH);
			conv_chan  <= cur_d;
		end
	end

	// ==========================================
	// global result and flags
	always @(posedge clk) begin
		if (!rstn) begin
			res_q   <= `ADSB_RES_RST;
			gch_q   <= `ADSB_CHAN_RST;
			fresh_q <= 1'b0;
			ovr_q   <= 1'b0;
			sflag_q <= 1'b0;
		end else begin
			if (state_q == `ADSB_ST_WAIT && conv_done) begin
				res_q   <= conv_result;
				gch_q   <= cur_q;
				fresh_q <= 1'b1;
				ovr_q   <= fresh_q | (ovr_q & ~rd_gres);
			end else if (rd_gres) begin
				fresh_q <= 1'b0;
				ovr_q   <= 1'b0;
			end
			// R16: sequence-end flag, set wins
			if (eos_d) begin
				sflag_q <= 1'b1;
			end else if (dma_clr || (wr_stat && pwdata[`ADSB_SFLAG_BIT])) begin
				sflag_q <= 1'b0;
			end
		end
	end

	// R13: R14: flag source by mode
	assign seq_flag = mode_q ? sflag_q : fresh_q;
	// R15: R17: overrun gated by mode
	assign ovr_irq = ovr_q & ovr_ie_q & ~mode_q;
endmodule // adsb_seq_ctrl
`default_nettype wire

/* bench/adsb_seq_ctrl_assertions.sv */
// concurrent checks on the sequence b control ports
`timescale 1ns/100ps
`default_nettype none
module adsb_seq_chk (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        conv_start,
	input wire logic [3:0]  conv_chan,
	input wire logic        conv_done,
	input wire logic        dma_clr,
	input wire logic        seq_flag,
	input wire logic        ovr_irq
);
	// ====
	// shadow of the control register
	logic [31:0] ctrl_q;
	wire         acc = psel & penable;
	always @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= 32'h0000_0000;
		end else if (acc & pwrite & paddr == 12'h000) begin
			ctrl_q <= pwdata;
		end
	end
	// ====
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	start_reads_zero_a:
		assert property (acc & !pwrite & paddr == 12'h000 |-> !prdata[26])
		else $error("start read as one");
	start_one_cycle_a:
		assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	chan_enabled_a:
		assert property (conv_start |-> ctrl_q[conv_chan])
		else $error("channel not enabled");
	ovr_mode_a:
		assert property (ctrl_q[30] |-> !ovr_irq)
		else $error("overrun in mode one");
	fresh_mirror_a:
		assert property (acc & !pwrite & paddr == 12'h004 & !ctrl_q[30] |-> prdata[31] == seq_flag)
		else $error("flag differs from fresh bit");
	eos_set_a:
		assert property (ctrl_q[30] & $past(ctrl_q[30]) & $rose(seq_flag)
			|-> $past(conv_done) | $past(conv_done, 2) | $past(conv_done, 3))
		else $error("flag rose without end of pass");
	eos_hold_a:
		assert property (ctrl_q[30] & seq_flag & !dma_clr & !(acc & pwrite) |=> seq_flag)
		else $error("flag dropped by itself");
	burst_loop_a:
		assert property (ctrl_q[31] & ctrl_q[27] & conv_done |-> ##[1:8] conv_start)
		else $error("burst did not relaunch");
endmodule // adsb_seq_chk
bind adsb_seq_ctrl adsb_seq_chk i_chk (.clk(clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .conv_start(conv_start), .conv_chan(conv_chan),
	.conv_done(conv_done), .dma_clr(dma_clr), .seq_flag(seq_flag),
	.ovr_irq(ovr_irq));
`default_nettype wire

/* bench/adsb_conv_model.sv */
// converter model: done pulse and result a fixed time after each start
`timescale 1ns/100ps
`default_nettype none
module adsb_conv_model #(
	parameter int LAT = 4
) (
	input  wire logic        clk,
	input  wire logic        conv_start,
	input  wire logic [3:0]  conv_chan,
	output var  logic        conv_done,
	output var  logic [11:0] conv_result
);
	int          cnt = 0;
	logic [11:0] last_q = 12'h000;
	initial conv_done = 1'b0;
	initial conv_result = 12'hfff;
	// result shows the inverse of the last value outside a done pulse
	always @(posedge clk) begin
		cnt <= conv_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
		conv_done <= cnt == 1;
		conv_result <= cnt == 1 ? {conv_chan, 8'h5a} : ~last_q;
		if (cnt == 1) begin
			last_q <= {conv_chan, 8'h5a};
		end
	end
endmodule // adsb_conv_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for sequence b launch and flag control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        dma_clr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [7:0]  hw_trig = 8'h00;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [11:0] conv_result;
	logic [3:0]  conv_chan;
	logic        pready, pslverr, err, conv_start, conv_done, seq_flag, ovr_irq;
	int          mismatches = 0;
	int          comparisons = 0;
	int          lat [2];
	int          n;
	always #2.5 clk = ~clk;
	adsb_seq_ctrl i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_trig(hw_trig), .conv_start(conv_start),
		.conv_chan(conv_chan), .conv_done(conv_done), .conv_result(conv_result),
		.dma_clr(dma_clr), .seq_flag(seq_flag), .ovr_irq(ovr_irq));
	adsb_conv_model i_conv (.clk(clk), .conv_start(conv_start), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_result(conv_result));
	// ====
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic want(input logic [3:0] ch, output int k);
		k = 0;
		while (conv_start !== 1'b1 && k < 200) begin
			k++;
			@(posedge clk);
		end
		check(conv_start, 1'b1);
		check(conv_chan, ch);
		@(posedge clk);
	endtask
	task automatic quiet(input int cyc);
		int c = 0;
		repeat (cyc) begin
			@(posedge clk);
			c += conv_start;
		end
		check(c, 0);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#50000;
		mismatches++;
		complete_run();
	end
	// ====
	// tests
	// long pulses, no start in burst, reserved zero
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0);
		check(err, 1'b1);
		apb(1'b1, 12'h000, 32'h0400_0003);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0000_0003);
		quiet(30);
		$display("registers done");
		apb(1'b1, 12'h000, 32'hc400_0005);
		want(4'h0, n);
		want(4'h2, n);
		quiet(20);
		check(seq_flag, 1'b1);
		repeat (5) @(posedge clk);
		check(seq_flag, 1'b1);
		dma_clr <= 1'b1;
		@(posedge clk);
		dma_clr <= 1'b0;
		repeat (2) @(posedge clk);
		check(seq_flag, 1'b0);
		$display("sequence end done");
		apb(1'b1, 12'h008, 32'h0000_0002);
		apb(1'b1, 12'h000, 32'h8400_0005);
		want(4'h0, n);
		want(4'h2, n);
		quiet(20);
		check(seq_flag, 1'b1);
		check(ovr_irq, 1'b1);
		apb(1'b1, 12'h000, 32'hc000_0005);
		@(posedge clk);
		check(ovr_irq, 1'b0);
		apb(1'b1, 12'h000, 32'h8000_0005);
		apb(1'b0, 12'h004, 32'h0);
		check(rd & 32'hfc00_fff0, 32'hc800_25a0);
		@(posedge clk);
		check(seq_flag, 1'b0);
		$display("per conversion done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 32'h0);
			hw_trig <= {8{~i[0]}};
			quiet(6);
			apb(1'b1, 12'h000, {1'b1, 11'h0, i[1], i[0], 6'h03, 12'h002});
			hw_trig[5] <= i[0];
			quiet(10);
			hw_trig[3] <= i[0];
			want(4'h1, lat[i[1]]);
			quiet(20);
		end
		check(lat[0] - lat[1], 2);
		$display("triggers done");
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h008, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'hd000_0006);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h000, 32'hd400_0006);
			want(i[0] ? 4'h2 : 4'h1, n);
			quiet(20);
			check(seq_flag, i != 0);
		end
		$display("single step done");
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'h8800_0008);
		want(4'h3, n);
		want(4'h3, n);
		apb(1'b1, 12'h000, 32'h8000_0008);
		quiet(40);
		$display("burst done");
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'h8400_0007);
		want(4'h0, n);
		apb(1'b1, 12'h000, 32'h0000_0007);
		quiet(30);
		apb(1'b1, 12'h000, 32'h8400_0007);
		want(4'h1, n);
		$display("disable done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
